// ### hrsc_dev.sv
`timescale 1ns/10ps
module hrsc_dev
	import hrsc_pkg::*;
#(
	parameter int CTX_W = HRSC_CTX_W,
	parameter int CFG_W = HRSC_CFG_W
)
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_b,
	hrsc_if.dev                   bus,
	input  wire logic [CTX_W-1:0] i_ctx_wr_data,
	input  wire logic             i_ctx_wr,
	input  wire logic [CFG_W-1:0] i_cfg_wr_data,
	input  wire logic             i_cfg_wr,
	output logic      [CTX_W-1:0] o_ctx,
	output logic      [CFG_W-1:0] o_cfg,
	output logic                  o_out_en,
	output logic                  o_func_active,
	output hrsc_state_t           o_state
);
	// ****************************************************************
	// Pin positions in the synchroniser
	// ****************************************************************
	localparam int PIN_N    = 3;
	localparam int PIN_COLD = 0;
	localparam int PIN_BUSR = 1;
	localparam int PIN_SUSP = 2;
	localparam int SYNC_N   = HRSC_SYNC_STAGES;

	// ****************************************************************
	// State
	// ****************************************************************
	// The synchroniser clears to zero, which reads as both resets
	// asserted: the device stays quiet until the pins are seen high.
	typedef struct packed
	{
		logic [SYNC_N-1:0][PIN_N-1:0] sync;
		hrsc_state_t                  st;
		logic [CTX_W-1:0]             ctx;
		logic [CFG_W-1:0]             cfg;
		logic                         out_en;
		logic                         func;
	} hrsc_dev_t;

	hrsc_dev_t s_q;
	hrsc_dev_t s_d;

	wire logic [PIN_N-1:0]             pin_raw;
	wire logic [SYNC_N-1:0][PIN_N-1:0] sync_nxt;
	wire logic [PIN_N-1:0]             pin_sync;

	logic cold_a;
	logic busr_a;
	logic susp;

	// ****************************************************************
	// Pin gathering
	// ****************************************************************
	assign pin_raw[PIN_COLD] = bus.cold_reset_in_b;
	assign pin_raw[PIN_BUSR] = bus.host_bus_reset_in_b;
	assign pin_raw[PIN_SUSP] = bus.suspend_in;

	// ****************************************************************
	// Synchronisers
	// ****************************************************************
	// Pins are asynchronous to the clock; only the last stage is read
	// by the control logic, the first stage feeds the chain alone.
	genvar b;
	genvar k;
	generate
		for (b = 0; b < PIN_N; b++)
		begin : g_pin
			for (k = 0; k < SYNC_N; k++)
			begin : g_stage
				if (k == 0)
				begin : g_first
					assign sync_nxt[k][b] = pin_raw[b];
				end
				else
				begin : g_next
					assign sync_nxt[k][b] = s_q.sync[k-1][b];
				end
			end
			assign pin_sync[b] = s_q.sync[SYNC_N-1][b];
		end
	endgenerate

	// ****************************************************************
	// Decoded reset levels
	// ****************************************************************
	// Both reset pins are active low; suspend is active high
	assign cold_a = ~pin_sync[PIN_COLD];
	assign busr_a = ~pin_sync[PIN_BUSR];
	assign susp   = pin_sync[PIN_SUSP];

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Cold reset outranks bus reset. Suspend only protects the
	// register contents; the outputs float in every reset regardless.
	always_comb
	begin
		s_d      = s_q;
		s_d.sync = sync_nxt;
		if (cold_a)
		begin
			s_d.out_en = 1'b0;
			s_d.func   = 1'b0;
			if (susp)
			begin
				s_d.st = HRSC_ST_HOLD;
			end
			else
			begin
				s_d.st  = HRSC_ST_COLD;
				s_d.ctx = HRSC_CTX_RST[CTX_W-1:0];
				s_d.cfg = HRSC_CFG_RST[CFG_W-1:0];
			end
		end
		else if (busr_a)
		begin
			s_d.out_en = 1'b0;
			s_d.func   = 1'b0;
			if (susp)
			begin
				s_d.st = HRSC_ST_HOLD;
			end
			else
			begin
				// Wake context survives the bus reset
				s_d.st  = HRSC_ST_BUSR;
				s_d.cfg = HRSC_CFG_RST[CFG_W-1:0];
			end
		end
		else
		begin
			// Writes are refused in every reset state, so a host
			// cannot disturb context that suspend is protecting
			s_d.st     = HRSC_ST_RUN;
			s_d.out_en = 1'b1;
			s_d.func   = 1'b1;
			if (i_ctx_wr)
			begin
				s_d.ctx = i_ctx_wr_data;
			end
			if (i_cfg_wr)
			begin
				s_d.cfg = i_cfg_wr_data;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// The reset branch loads constants only
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s_q        <= '0;
			s_q.st     <= HRSC_ST_COLD;
			s_q.ctx    <= HRSC_CTX_RST[CTX_W-1:0];
			s_q.cfg    <= HRSC_CFG_RST[CFG_W-1:0];
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Every output is a flop of the state, no logic after it
	assign o_ctx         = s_q.ctx;
	assign o_cfg         = s_q.cfg;
	assign o_out_en      = s_q.out_en;
	assign o_func_active = s_q.func;
	assign o_state       = s_q.st;
endmodule

// ### hrsc_pkg.sv
// ****************************************************************
// Shared constants and types
// ****************************************************************
package hrsc_pkg;
	localparam int HRSC_SYNC_STAGES = 2;
	localparam int HRSC_CTX_W       = 8;
	localparam int HRSC_CFG_W       = 8;
	localparam logic [7:0] HRSC_CTX_RST = 8'h00;
	localparam logic [7:0] HRSC_CFG_RST = 8'h00;
	localparam logic [3:0] HRSC_BOOT_CYC = 4'h4;

	typedef enum logic [1:0]
	{
		HRSC_ST_COLD  = 2'b00,
		HRSC_ST_RUN   = 2'b01,
		HRSC_ST_BUSR  = 2'b11,
		HRSC_ST_HOLD  = 2'b10
	} hrsc_state_t;

	typedef enum logic [1:0]
	{
		HRSC_HB_BOOT = 2'b00,
		HRSC_HB_RUN  = 2'b01,
		HRSC_HB_BUSR = 2'b11
	} hrsc_hstate_t;
endpackage

// ### hrsc_if.sv
`timescale 1ns/10ps
// ****************************************************************
// Reset and suspend wires between board logic and the controller
// ****************************************************************
interface hrsc_if;
	logic cold_reset_in_b;
	logic host_bus_reset_in_b;
	logic suspend_in;

	modport dev
	(
		input cold_reset_in_b,
		input host_bus_reset_in_b,
		input suspend_in
	);
	modport brd
	(
		output cold_reset_in_b,
		output host_bus_reset_in_b,
		output suspend_in
	);
endinterface

// ### hrsc_brd.sv
`timescale 1ns/10ps
// Board reset logic: cold and bus reset together at boot, bus reset afterwards (with cold reset on each one when WAKE_D3 is 0)
module hrsc_brd
	import hrsc_pkg::*;
#(
	parameter bit WAKE_D3 = 1'b1
)
(
	input  wire logic  i_sys_clk,
	input  wire logic  i_rst_b,
	input  wire logic  i_bus_reset_req,
	input  wire logic  i_suspend_req,
	hrsc_if.brd        bus,
	output logic       o_booted
);
	typedef struct packed
	{
		hrsc_hstate_t st;
		logic [3:0]   cnt;
		logic         cold_b;
		logic         busr_b;
		logic         susp;
		logic         booted;
	} hrsc_brd_t;

	hrsc_brd_t s_q;
	hrsc_brd_t s_d;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		s_d      = s_q;
		s_d.susp = i_suspend_req;
		case (s_q.st)
			HRSC_HB_BOOT:
			begin
				s_d.cold_b = 1'b0;
				s_d.busr_b = 1'b0;
				s_d.cnt    = s_q.cnt + 4'h1;
				if (s_q.cnt == HRSC_BOOT_CYC)
				begin
					s_d.st     = HRSC_HB_RUN;
					s_d.booted = 1'b1;
					s_d.cold_b = 1'b1;
					s_d.busr_b = 1'b1;
				end
			end
			HRSC_HB_RUN, HRSC_HB_BUSR:
			begin
				s_d.st     = i_bus_reset_req ? HRSC_HB_BUSR : HRSC_HB_RUN;
				s_d.busr_b = ~i_bus_reset_req;
				// Cold reset follows bus reset when no wake is needed
				s_d.cold_b = WAKE_D3 ? 1'b1 : ~i_bus_reset_req;
			end
			default:
			begin
				s_d.st = HRSC_HB_BOOT;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign bus.cold_reset_in_b     = s_q.cold_b;
	assign bus.host_bus_reset_in_b = s_q.busr_b;
	assign bus.suspend_in          = s_q.susp;
	assign o_booted                = s_q.booted;
endmodule

// ### hrsc_assertions.sv
`timescale 1ns/10ps
// ****************************************************************
// Reset outcome checks
// ****************************************************************
module hrsc_assertions
	import hrsc_pkg::*;
(
	input wire logic       i_sys_clk,
	input wire logic       i_rst_b,
	input wire logic       cold_reset_in_b,
	input wire logic       host_bus_reset_in_b,
	input wire logic       suspend_in,
	input wire logic [7:0] o_ctx,
	input wire logic [7:0] o_cfg,
	input wire logic       o_out_en,
	input wire logic       o_func_active,
	input hrsc_state_t     o_state
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	a_cold_clears:
	assert property (o_state == HRSC_ST_COLD |-> o_ctx == 8'h00 && o_cfg == 8'h00)
		else $error("cold state kept data");
	a_cold_idle:
	assert property (o_state == HRSC_ST_COLD |-> !o_func_active && !o_out_en)
		else $error("cold state active");
	a_cold_float:
	assert property (!cold_reset_in_b [*4] |-> !o_out_en)
		else $error("driving in cold reset");
	a_bus_float:
	assert property (!host_bus_reset_in_b [*4] |-> !o_out_en && !o_func_active)
		else $error("driving in bus reset");
	a_hold_float:
	assert property (o_state == HRSC_ST_HOLD |-> !o_out_en)
		else $error("driving in suspend");
	a_hold_keeps:
	assert property (o_state == HRSC_ST_HOLD && $past(o_state) == HRSC_ST_HOLD
		|-> $stable(o_ctx) && $stable(o_cfg)) else $error("suspend lost data");
	a_bus_keeps_ctx:
	assert property (o_state == HRSC_ST_BUSR |-> ##1 o_state != HRSC_ST_BUSR
		|| $stable(o_ctx)) else $error("bus reset changed context");
	a_release_runs:
	assert property ((cold_reset_in_b && host_bus_reset_in_b) [*4] |->
		o_state == HRSC_ST_RUN && o_out_en) else $error("no run after reset");
endmodule

// ### host_reset_suspend_control_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, a) \
	begin \
		samples_checked++; \
		if ((a) !== (e)) \
		begin \
			bad_count++; \
			$display("wrong value %s exp %h got %h", n, e, a); \
		end \
	end
module host_reset_suspend_control_tb;
	import hrsc_pkg::*;
	typedef struct {logic br, sp; logic [7:0] d, cx, cf; hrsc_state_t st;} hrsc_row_t;
	logic i_sys_clk = 1'b0, i_rst_b = 1'b0, br = 1'b0, sp = 1'b0, wr = 1'b0;
	logic brd_rst_b = 1'b0;
	logic [7:0] wd = 8'h00, o_ctx, o_cfg;
	logic o_out_en, o_func_active, booted;
	hrsc_state_t o_state;
	int bad_count = 0, samples_checked = 0, cyc = 0;
	// Rows: bus reset, suspend, data written first, then expected outcome
	hrsc_row_t rows[5] = '{'{0, 0, 8'h5A, 8'h5A, 8'h5A, HRSC_ST_RUN},
		'{1, 0, 8'h00, 8'h5A, 8'h00, HRSC_ST_BUSR},
		'{0, 0, 8'h3C, 8'h3C, 8'h3C, HRSC_ST_RUN},
		'{1, 1, 8'h00, 8'h3C, 8'h3C, HRSC_ST_HOLD},
		'{0, 0, 8'h00, 8'h3C, 8'h3C, HRSC_ST_RUN}};
	hrsc_if bus_if();
	hrsc_brd hrsc_brd_i (.i_sys_clk(i_sys_clk), .i_rst_b(brd_rst_b),
		.i_bus_reset_req(br), .i_suspend_req(sp), .bus(bus_if), .o_booted(booted));
	hrsc_dev hrsc_dev_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .bus(bus_if),
		.i_ctx_wr_data(wd), .i_ctx_wr(wr), .i_cfg_wr_data(wd), .i_cfg_wr(wr),
		.o_ctx(o_ctx), .o_cfg(o_cfg), .o_out_en(o_out_en),
		.o_func_active(o_func_active), .o_state(o_state));
	hrsc_assertions hrsc_assertions_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.cold_reset_in_b(bus_if.cold_reset_in_b), .suspend_in(bus_if.suspend_in),
		.host_bus_reset_in_b(bus_if.host_bus_reset_in_b), .o_ctx(o_ctx),
		.o_cfg(o_cfg), .o_out_en(o_out_en), .o_func_active(o_func_active),
		.o_state(o_state));
	always #2.5 i_sys_clk = ~i_sys_clk;
	task print_verdict;
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task settle;
		repeat (8) @(posedge i_sys_clk);
	endtask
	task pulse_write(input logic [7:0] v);
		wd <= v;
		wr <= 1'b1;
		@(posedge i_sys_clk);
		wr <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	// Whole run needs under 150 cycles; far above that means a hang
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (2) @(posedge i_sys_clk);
		`CHK("state", HRSC_ST_COLD, o_state)
		`CHK("out_en", 1'b0, o_out_en)
		`CHK("booted", 1'b0, booted)
		i_rst_b   <= 1'b1;
		brd_rst_b <= 1'b1;
		settle();
		settle();
		`CHK("booted", 1'b1, booted)
		foreach (rows[r])
		begin
			br <= rows[r].br;
			sp <= rows[r].sp;
			settle();
			if (rows[r].d != 8'h00)
				pulse_write(rows[r].d);
			settle();
			`CHK("state", rows[r].st, o_state)
			`CHK("ctx", rows[r].cx, o_ctx)
			`CHK("cfg", rows[r].cf, o_cfg)
			`CHK("out_en", rows[r].st == HRSC_ST_RUN, o_out_en)
		end
		br <= 1'b1;
		settle();
		pulse_write(8'h77);
		settle();
		`CHK("ctx", 8'h3C, o_ctx)
		`CHK("cfg", 8'h00, o_cfg)
		`CHK("func", 1'b0, o_func_active)
		// Board reset mid-run brings cold reset back
		br        <= 1'b0;
		brd_rst_b <= 1'b0;
		settle();
		`CHK("state", HRSC_ST_COLD, o_state)
		`CHK("ctx", 8'h00, o_ctx)
		`CHK("cfg", 8'h00, o_cfg)
		`CHK("out_en", 1'b0, o_out_en)
		brd_rst_b <= 1'b1;
		settle();
		settle();
		`CHK("state", HRSC_ST_RUN, o_state)
		`CHK("func", 1'b1, o_func_active)
		print_verdict();
	end
endmodule
